// [rtl/msp_params.svh]
// Register map, field positions, reset values and timing counts
`ifndef MSP_PARAMS_SVH
`define MSP_PARAMS_SVH
`define MSP_NPORTS        12
`define MSP_CLK_KHZ       200000
`define MSP_TRIG_MIN_NS   500
`define MSP_TRIG_MIN_CYC  ((`MSP_TRIG_MIN_NS * `MSP_CLK_KHZ + 999999) / 1000000)
`define MSP_DAC_SLOT_US   40
`define MSP_DAC_SLOT_CYC  (`MSP_DAC_SLOT_US * `MSP_CLK_KHZ / 1000)
`define MSP_RATE0_KSPS    400
`define MSP_RATE1_KSPS    333
`define MSP_RATE2_KSPS    250
`define MSP_RATE3_KSPS    200
`define MSP_OFF_CFG       8'h00
`define MSP_OFF_DAC       8'h40
`define MSP_OFF_ADC       8'h80
`define MSP_OFF_CTRL      8'hC0
`define MSP_OFF_PRESET0   8'hC4
`define MSP_OFF_PRESET1   8'hC8
`define MSP_OFF_GPO       8'hCC
`define MSP_OFF_GPI       8'hD0
`define MSP_OFF_EDGE      8'hD4
`define MSP_OFF_OVC       8'hD8
`define MSP_OFF_MASK      8'hDC
`define MSP_CFG_MODE_LSB  0
`define MSP_CFG_AVG_LSB   4
`define MSP_CFG_REF_BIT   7
`define MSP_CFG_NEG_LSB   8
`define MSP_CFG_EDGE_LSB  12
`define MSP_CTRL_MODE_LSB 0
`define MSP_CTRL_RATE_LSB 2
`define MSP_CTRL_TRIG_BIT 4
`define MSP_CTRL_JUMP_BIT 5
`define MSP_CTRL_REF_BIT  6
`define MSP_CTRL_PSEL_LSB 7
`define MSP_CTRL_TEMP_LSB 9
`define MSP_CTRL_RESET    12'h00C
`define MSP_MASK_RESET    24'hFFFFFF
`endif

// [rtl/msp_pkg.sv]
// Types shared by the port sequencer
package msp_pkg;
   typedef logic [3:0] msp_idx_t;
   typedef enum logic [1:0] {
      MSP_ADC_IDLE   = 2'h0,
      MSP_ADC_SWEEP  = 2'h1,
      MSP_ADC_SINGLE = 2'h2,
      MSP_ADC_CONT   = 2'h3
   } msp_adc_mode_t;
   typedef enum logic [3:0] {
      MSP_PM_HIZ       = 4'h0,
      MSP_PM_DAC       = 4'h1,
      MSP_PM_LIN       = 4'h2,
      MSP_PM_LOUT      = 4'h3,
      MSP_PM_ADC_SE    = 4'h4,
      MSP_PM_ADC_DIFF  = 4'h5,
      MSP_PM_ADC_PDIFF = 4'h6
   } msp_port_mode_t;
   typedef enum logic [1:0] {
      MSP_S_IDLE = 2'b00,
      MSP_S_WAIT = 2'b01,
      MSP_S_CONV = 2'b11,
      MSP_S_NEXT = 2'b10
   } msp_state_t;
endpackage : msp_pkg

// [rtl/msp_adc_mem.sv]
// Result store for the per-port ADC data words
`timescale 1ns/1ps
module msp_adc_mem #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 12,
   parameter int AW    = 4
) (
   input  wire logic             clk_i,     // System clock
   input  wire logic             reset_n_i, // Async reset, active low
   input  wire logic             wr_en_i,   // Write strobe
   input  wire logic [AW-1:0]    wr_addr_i, // Write address
   input  wire logic [WIDTH-1:0] wr_data_i, // Write data
   input  wire logic [AW-1:0]    rd_addr_i, // Read address
   output logic      [WIDTH-1:0] rd_data_o  // Registered read data
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_data_o <= '0;
      end else begin
         rd_data_o <= mem[rd_addr_i];
      end
   end
endmodule : msp_adc_mem

// [rtl/msp_sequencer.sv]
// ADC and DAC port sequencer with APB register file
`timescale 1ns/1ps
`include "msp_params.svh"
module msp_sequencer #(
   parameter int DAC_SLOT_CYCLES = `MSP_DAC_SLOT_CYC,
   parameter int TRIG_MIN_CYCLES = `MSP_TRIG_MIN_CYC
) (
   input  wire logic             clk_i,                        // 200 MHz clock
   input  wire logic             reset_n_i,                    // Async reset, active low
   input  wire logic [7:0]       paddr_i,                      // APB address
   input  wire logic             psel_i,                       // APB select
   input  wire logic             penable_i,                    // APB enable
   input  wire logic             pwrite_i,                     // APB direction
   input  wire logic [31:0]      pwdata_i,                     // APB write data
   output logic      [31:0]      prdata_o,                     // APB read data
   output logic                  pready_o,                     // APB ready
   output logic                  pslverr_o,                    // APB error
   input  wire logic             convert_trigger_n_i,          // Trigger pin, low
   output logic                  adc_start_o,                  // Conversion start
   output msp_pkg::msp_idx_t     adc_pos_o,                    // Positive input port
   output msp_pkg::msp_idx_t     adc_neg_o,                    // Negative input port
   output logic                  adc_neg_gnd_o,                // Negative input grounded
   output logic                  adc_ref_dac_o,                // Use DAC reference
   output logic                  adc_temp_o,                   // Temperature slot
   input  wire logic             adc_done_i,                   // Conversion done
   input  wire logic [11:0]      adc_result_i,                 // Offset binary result
   output logic [2:0]            temperature_channel_select_o, // Temperature select
   output logic                  dac_load_o,                   // DAC update pulse
   output msp_pkg::msp_idx_t     dac_port_o,                   // DAC target port
   output logic [11:0]           dac_data_o,                   // DAC code
   output logic                  dac_ref_ext_o,                // External DAC reference
   input  wire logic [11:0]      ovc_i,                        // Overcurrent per port
   input  wire logic [11:0]      logic_input_port_i,           // Comparator outputs
   output logic [11:0]           logic_output_port_o,          // Logic output states
   output logic                  irq_out_n_o,                  // Interrupt pin value
   output logic                  irq_out_n_oe_o                // Interrupt pin enable
);
   import msp_pkg::*;

   localparam int NP = `MSP_NPORTS;
   localparam int TW = $clog2(TRIG_MIN_CYCLES + 1);
   localparam int DW = $clog2(DAC_SLOT_CYCLES);

   function automatic logic [4:0] find_from(input logic [11:0] mask, input logic [4:0] from);
      logic [4:0] r;
      r = 5'h00;
      for (int i = NP - 1; i >= 0; i--) begin
         if (mask[i] && (i >= int'(from))) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction : find_from

   function automatic logic hit_arr(input logic [7:0] a, input logic [7:0] base);
      return (a[7:6] == base[7:6]) && (a[5:2] < 4'(NP)) && (a[1:0] == 2'h0);
   endfunction : hit_arr

   function automatic logic [9:0] rate_cyc(input logic [1:0] sel);
      unique case (sel)
         2'h0: return 10'(`MSP_CLK_KHZ / `MSP_RATE0_KSPS);
         2'h1: return 10'(`MSP_CLK_KHZ / `MSP_RATE1_KSPS);
         2'h2: return 10'(`MSP_CLK_KHZ / `MSP_RATE2_KSPS);
         2'h3: return 10'(`MSP_CLK_KHZ / `MSP_RATE3_KSPS);
      endcase
   endfunction : rate_cyc

   logic [13:0]   cfg [NP];
   logic [11:0]   dac_data [NP];
   logic [11:0]   ctrl;
   logic [11:0]   preset0;
   logic [11:0]   preset1;
   logic [11:0]   logic_output_port;
   logic [11:0]   lin_q;
   logic [11:0]   edge_st;
   logic [11:0]   ovc_st;
   logic [23:0]   irq_mask;
   logic [11:0]   adc_mask;
   logic [11:0]   dac_mask;
   logic [11:0]   lin_mask;
   logic [11:0]   lout_mask;
   logic [11:0]   adc_valid;
   logic [18:0]   acc [NP];
   logic [6:0]    cnt [NP];
   msp_state_t    state;
   msp_adc_mode_t adc_mode;
   logic [3:0]    chan;
   logic          temp_slot;
   logic          sweeping;
   logic [4:0]    single_ptr;
   logic [TW-1:0] low_cnt;
   logic          soft_trig;
   logic [9:0]    rate_cnt;
   logic [DW-1:0] slot_cnt;
   logic [3:0]    dac_ptr;
   logic          jump_pend;
   logic [3:0]    jump_port;
   logic [31:0]   rd_q;
   logic          err_q;
   logic          adc_rd_q;
   logic          adc_rd_valid;
   logic [11:0]   mem_rd;
   logic          mem_we;
   logic [11:0]   mem_wd;

   wire        setup    = psel_i & ~penable_i;
   wire        wr       = psel_i & penable_i & pwrite_i;
   wire [3:0]  widx     = paddr_i[5:2];
   wire        wr_cfg   = wr && hit_arr(paddr_i, `MSP_OFF_CFG);
   wire        wr_dac   = wr && hit_arr(paddr_i, `MSP_OFF_DAC);
   wire        wr_ctrl  = wr && (paddr_i == `MSP_OFF_CTRL);
   wire [1:0]  new_mode = pwdata_i[`MSP_CTRL_MODE_LSB +: 2];
   wire        have_temp = (ctrl[`MSP_CTRL_TEMP_LSB +: 3] != 3'h0);
   wire        rate_tick = (rate_cnt == 10'h000);
   wire        pin_trig  = ~convert_trigger_n_i && (low_cnt == TW'(TRIG_MIN_CYCLES - 1));
   wire        trig      = pin_trig | soft_trig;
   wire [4:0]  first     = find_from(adc_mask, 5'h00);
   wire [4:0]  after     = find_from(adc_mask, 5'({1'b0, chan} + 5'h01));
   wire [4:0]  cur       = find_from(adc_mask, single_ptr);
   wire [4:0]  cur_sel   = cur[4] ? cur : first;
   wire [4:0]  dac_first = find_from(dac_mask, 5'h00);
   wire [4:0]  dac_after = find_from(dac_mask, 5'({1'b0, dac_ptr} + 5'h01));
   wire        slot_end  = (slot_cnt == DW'(DAC_SLOT_CYCLES - 1));
   // Mode change between two active modes
   wire        clear_all = wr_ctrl && (new_mode != 2'h0) && (adc_mode != MSP_ADC_IDLE) &&
                           (new_mode != 2'(adc_mode));
   wire        conv_done = (state == MSP_S_CONV) && adc_done_i && !temp_slot;

   assign adc_mode = msp_adc_mode_t'(ctrl[`MSP_CTRL_MODE_LSB +: 2]);

   for (genvar g = 0; g < NP; g++) begin : g_port
      wire [3:0] m = cfg[g][`MSP_CFG_MODE_LSB +: 4];
      assign adc_mask[g]  = (m == MSP_PM_ADC_SE) || (m == MSP_PM_ADC_DIFF) ||
                            (m == MSP_PM_ADC_PDIFF);
      assign dac_mask[g]  = (m == MSP_PM_DAC) || (m == MSP_PM_LIN) || (m == MSP_PM_LOUT);
      assign lin_mask[g]  = (m == MSP_PM_LIN);
      assign lout_mask[g] = (m == MSP_PM_LOUT);
   end

   // Port configuration and DAC data words
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < NP; i++) begin
            cfg[i]      <= 14'h0000;
            dac_data[i] <= 12'h000;
         end
      end else begin
         if (wr_cfg) begin
            cfg[widx] <= pwdata_i[13:0];
         end
         if (wr_dac) begin
            dac_data[widx] <= pwdata_i[11:0];
         end
      end
   end

   // Global control, presets, output data, mask
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl      <= `MSP_CTRL_RESET;
         soft_trig <= 1'b0;
         preset0   <= 12'h000;
         preset1   <= 12'h000;
         logic_output_port       <= 12'h000;
         irq_mask  <= `MSP_MASK_RESET;
      end else begin
         soft_trig <= wr_ctrl && pwdata_i[`MSP_CTRL_TRIG_BIT];
         if (wr_ctrl) begin
            ctrl <= pwdata_i[11:0] & ~(12'h001 << `MSP_CTRL_TRIG_BIT);
         end
         if (wr && (paddr_i == `MSP_OFF_PRESET0)) begin
            preset0 <= pwdata_i[11:0];
         end
         if (wr && (paddr_i == `MSP_OFF_PRESET1)) begin
            preset1 <= pwdata_i[11:0];
         end
         if (wr && (paddr_i == `MSP_OFF_GPO)) begin
            logic_output_port <= pwdata_i[11:0];
         end
         if (wr && (paddr_i == `MSP_OFF_MASK)) begin
            irq_mask <= pwdata_i[23:0];
         end
      end
   end

   // APB read path, captured in the setup phase
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_q         <= 32'h0000_0000;
         err_q        <= 1'b0;
         adc_rd_q     <= 1'b0;
         adc_rd_valid <= 1'b0;
      end else if (setup) begin
         rd_q         <= 32'h0000_0000;
         err_q        <= 1'b0;
         adc_rd_q     <= hit_arr(paddr_i, `MSP_OFF_ADC);
         adc_rd_valid <= adc_valid[widx];
         if (hit_arr(paddr_i, `MSP_OFF_CFG)) begin
            rd_q <= {18'h00000, cfg[widx]};
         end else if (hit_arr(paddr_i, `MSP_OFF_DAC)) begin
            rd_q <= {20'h00000, dac_data[widx]};
         end else if (!hit_arr(paddr_i, `MSP_OFF_ADC)) begin
            unique case (paddr_i)
               `MSP_OFF_CTRL:    rd_q <= {20'h00000, ctrl};
               `MSP_OFF_PRESET0: rd_q <= {20'h00000, preset0};
               `MSP_OFF_PRESET1: rd_q <= {20'h00000, preset1};
               `MSP_OFF_GPO:     rd_q <= {20'h00000, logic_output_port};
               `MSP_OFF_GPI:     rd_q <= {20'h00000, lin_q};
               `MSP_OFF_EDGE:    rd_q <= {20'h00000, edge_st};
               `MSP_OFF_OVC:     rd_q <= {20'h00000, ovc_st};
               `MSP_OFF_MASK:    rd_q <= {8'h00, irq_mask};
               default:          err_q <= 1'b1;
            endcase
         end
      end
   end

   assign prdata_o  = adc_rd_q ? (adc_rd_valid ? {20'h00000, mem_rd} : 32'h0000_0000) : rd_q;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & err_q;

   // Trigger pin low-time qualifier
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         low_cnt <= '0;
      end else if (convert_trigger_n_i) begin
         low_cnt <= '0;
      end else if (low_cnt != TW'(TRIG_MIN_CYCLES)) begin
         low_cnt <= low_cnt + TW'(1);
      end
   end

   // Conversion rate pacing
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rate_cnt <= 10'h000;
      end else if (rate_tick) begin
         rate_cnt <= rate_cyc(ctrl[`MSP_CTRL_RATE_LSB +: 2]) - 10'h001;
      end else begin
         rate_cnt <= rate_cnt - 10'h001;
      end
   end

   // ADC sequencer
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state      <= MSP_S_IDLE;
         chan       <= 4'h0;
         temp_slot  <= 1'b0;
         sweeping   <= 1'b0;
         single_ptr <= 5'h00;
      end else begin
         unique case (state)
            MSP_S_IDLE: begin
               if (((adc_mode == MSP_ADC_CONT) || (adc_mode == MSP_ADC_SWEEP && trig)) &&
                   (first[4] || have_temp)) begin
                  chan      <= first[3:0];
                  temp_slot <= ~first[4];
                  sweeping  <= 1'b1;
                  state     <= MSP_S_WAIT;
               end else if (adc_mode == MSP_ADC_SINGLE && trig && first[4]) begin
                  chan      <= cur_sel[3:0];
                  temp_slot <= 1'b0;
                  sweeping  <= 1'b0;
                  state     <= MSP_S_WAIT;
               end
            end
            MSP_S_WAIT: begin
               if (adc_mode == MSP_ADC_IDLE) begin
                  state <= MSP_S_IDLE;
               end else if (rate_tick) begin
                  state <= MSP_S_CONV;
               end
            end
            MSP_S_CONV: begin
               if (adc_done_i) begin
                  state <= MSP_S_NEXT;
               end
            end
            MSP_S_NEXT: begin
               if (!sweeping) begin
                  single_ptr <= (chan == 4'(NP - 1)) ? 5'h00 : 5'({1'b0, chan} + 5'h01);
                  state      <= MSP_S_IDLE;
               end else if (adc_mode == MSP_ADC_IDLE) begin
                  state <= MSP_S_IDLE;
               end else if (!temp_slot && after[4]) begin
                  chan  <= after[3:0];
                  state <= MSP_S_WAIT;
               end else if (!temp_slot && have_temp) begin
                  temp_slot <= 1'b1;
                  state     <= MSP_S_WAIT;
               end else begin
                  state <= MSP_S_IDLE;
               end
            end
         endcase
      end
   end

   // Converter input selection, launched on the rate tick
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         adc_start_o   <= 1'b0;
         adc_pos_o     <= 4'h0;
         adc_neg_o     <= 4'h0;
         adc_neg_gnd_o <= 1'b1;
         adc_ref_dac_o <= 1'b0;
         adc_temp_o    <= 1'b0;
      end else begin
         adc_start_o <= (state == MSP_S_WAIT) && rate_tick && (adc_mode != MSP_ADC_IDLE);
         if ((state == MSP_S_WAIT) && rate_tick && (adc_mode != MSP_ADC_IDLE)) begin
            adc_pos_o     <= chan;
            adc_neg_o     <= cfg[chan][`MSP_CFG_NEG_LSB +: 4];
            adc_neg_gnd_o <= (cfg[chan][3:0] == MSP_PM_ADC_SE);
            adc_ref_dac_o <= cfg[chan][`MSP_CFG_REF_BIT];
            adc_temp_o    <= temp_slot;
         end
      end
   end

   // Averaging and result write
   wire [18:0] sum   = acc[chan] + {7'h00, adc_result_i};
   wire [2:0]  nsh   = cfg[chan][`MSP_CFG_AVG_LSB +: 3];
   wire [6:0]  limit = 7'((8'h01 << nsh) - 8'h01);
   wire [11:0] avg   = 12'(sum >> nsh);
   assign mem_we = conv_done && (cnt[chan] == limit);
   assign mem_wd = (cfg[chan][3:0] == MSP_PM_ADC_SE) ? avg : {~avg[11], avg[10:0]};

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         adc_valid <= 12'h000;
         for (int i = 0; i < NP; i++) begin
            acc[i] <= 19'h00000;
            cnt[i] <= 7'h00;
         end
      end else begin
         if (conv_done) begin
            acc[chan] <= mem_we ? 19'h00000 : sum;
            cnt[chan] <= mem_we ? 7'h00 : cnt[chan] + 7'h01;
            adc_valid[chan] <= adc_valid[chan] | mem_we;
         end
         if (wr_cfg && (pwdata_i[`MSP_CFG_AVG_LSB +: 3] != cfg[widx][`MSP_CFG_AVG_LSB +: 3])) begin
            adc_valid[widx] <= 1'b0;
            acc[widx]       <= 19'h00000;
            cnt[widx]       <= 7'h00;
         end
         if (clear_all) begin
            adc_valid <= 12'h000;
            for (int i = 0; i < NP; i++) begin
               acc[i] <= 19'h00000;
               cnt[i] <= 7'h00;
            end
         end
      end
   end

   msp_adc_mem #(
      .WIDTH (12),
      .DEPTH (NP),
      .AW    (4)
   ) u_mem (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .wr_en_i   (mem_we),
      .wr_addr_i (chan),
      .wr_data_i (mem_wd),
      .rd_addr_i (widx),
      .rd_data_o (mem_rd)
   );

   // DAC refresh sequencer
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         slot_cnt   <= '0;
         dac_ptr    <= 4'h0;
         jump_pend  <= 1'b0;
         jump_port  <= 4'h0;
         dac_load_o <= 1'b0;
         dac_port_o <= 4'h0;
         dac_data_o <= 12'h000;
      end else begin
         slot_cnt   <= slot_end ? '0 : slot_cnt + DW'(1);
         dac_load_o <= slot_end && dac_mask[dac_ptr];
         if (slot_end) begin
            dac_port_o <= dac_ptr;
            unique case (ctrl[`MSP_CTRL_PSEL_LSB +: 2])
               2'h1:    dac_data_o <= preset0;
               2'h2:    dac_data_o <= preset1;
               default: dac_data_o <= dac_data[dac_ptr];
            endcase
            if (jump_pend) begin
               dac_ptr <= jump_port;
            end else begin
               dac_ptr <= dac_after[4] ? dac_after[3:0] : dac_first[3:0];
            end
         end
         if (wr_dac && ctrl[`MSP_CTRL_JUMP_BIT]) begin
            jump_pend <= 1'b1;
            jump_port <= widx;
         end else if (slot_end) begin
            jump_pend <= 1'b0;
         end
      end
   end

   // Logic ports, edge and overcurrent status, interrupt
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lin_q               <= 12'h000;
         edge_st             <= 12'h000;
         ovc_st              <= 12'h000;
         logic_output_port_o <= 12'h000;
         irq_out_n_oe_o      <= 1'b0;
      end else begin
         lin_q               <= logic_input_port_i;
         logic_output_port_o <= logic_output_port & lout_mask;
         for (int i = 0; i < NP; i++) begin
            edge_st[i] <= (edge_st[i] &
                           ~(wr && (paddr_i == `MSP_OFF_EDGE) && pwdata_i[i])) |
                          (lin_mask[i] &
                           ((cfg[i][`MSP_CFG_EDGE_LSB] & logic_input_port_i[i] & ~lin_q[i]) |
                            (cfg[i][`MSP_CFG_EDGE_LSB + 1] & ~logic_input_port_i[i] &
                             lin_q[i])));
         end
         ovc_st <= (ovc_st & ~({12{wr && (paddr_i == `MSP_OFF_OVC)}} & pwdata_i[11:0])) |
                   ovc_i;
         irq_out_n_oe_o <= |(ovc_st & ~irq_mask[11:0]) | |(edge_st & ~irq_mask[23:12]);
      end
   end

   assign irq_out_n_o                  = 1'b0;
   assign dac_ref_ext_o                = ctrl[`MSP_CTRL_REF_BIT];
   assign temperature_channel_select_o = ctrl[`MSP_CTRL_TEMP_LSB +: 3];
endmodule : msp_sequencer

// [test/msp_sequencer_sva.sv]
// Assertion checker for the port sequencer
`timescale 1ns/1ps
module msp_sva (
   input wire logic         clk_i,       // Clock
   input wire logic         reset_n_i,   // Reset, low
   input wire logic         psel_i,      // APB select
   input wire logic         penable_i,   // APB enable
   input wire logic         pslverr_o,   // APB error
   input wire logic         pready_o,    // APB ready
   input wire logic         adc_start_o, // Start pulse
   input msp_pkg::msp_idx_t adc_pos_o,   // Positive port
   input wire logic         adc_temp_o,  // Temperature slot
   input wire logic         dac_load_o,  // DAC pulse
   input msp_pkg::msp_idx_t dac_port_o,  // DAC port
   input wire logic         irq_out_n_o  // Interrupt value
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   a_err_access: assert property (pslverr_o |-> psel_i && penable_i) else $error("stray err");
   a_ready_high: assert property (pready_o) else $error("ready low");
   a_start_gap: assert property (adc_start_o |=> !adc_start_o [*8]) else $error("start gap");
   a_load_gap: assert property (dac_load_o |=> !dac_load_o [*8]) else $error("load gap");
   a_pos_range: assert property (adc_start_o && !adc_temp_o |-> adc_pos_o < 4'hC)
      else $error("bad port");
   a_pos_hold: assert property (!adc_start_o |-> $stable(adc_pos_o)) else $error("pos moved");
   a_dac_port: assert property (dac_load_o |-> dac_port_o < 4'hC) else $error("dac port");
   a_irq_level: assert property (irq_out_n_o == 1'b0) else $error("irq high");
endmodule : msp_sva
bind msp_sequencer msp_sva chk_u (.clk_i, .reset_n_i, .psel_i, .penable_i, .pslverr_o,
   .pready_o, .adc_start_o, .adc_pos_o, .adc_temp_o, .dac_load_o, .dac_port_o, .irq_out_n_o);

// [test/msp_adc_model.sv]
// Converter model answering start pulses
`timescale 1ns/1ps
module msp_adc_model #(
   parameter int LAT = 20
) (
   input wire logic        clk_i,   // Clock
   input wire logic        start_i, // Start pulse
   input wire logic [3:0]  pos_i,   // Selected port
   output logic            done_o,  // Done pulse
   output logic     [11:0] result_o // Result, offset binary
);
   int cnt = 0;
   always_ff @(posedge clk_i) begin
      done_o <= (cnt == 1);
      result_o <= (cnt == 1) ? {pos_i, 8'h00} : ~result_o;
      cnt <= start_i ? LAT : (cnt != 0) ? cnt - 1 : 0;
   end
endmodule : msp_adc_model

// [test/mixed_signal_port_sequencer_tb.sv]
// Testbench for the port sequencer
`timescale 1ns/1ps
`include "msp_params.svh"
module mixed_signal_port_sequencer_tb;
   logic              clk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic              convert_trigger_n_i = 1, pready_o, pslverr_o, er, adc_start_o;
   logic              adc_neg_gnd_o, adc_done_i, dac_load_o, irq_out_n_oe_o;
   logic [7:0]        paddr_i = 8'h00;
   logic [31:0]       pwdata_i = 32'h0, prdata_o, rd;
   logic [11:0]       adc_result_i, dac_data_o, ovc_i = 12'h000;
   msp_pkg::msp_idx_t adc_pos_o, dac_port_o;
   logic [4:0]        q[$];
   int                fails = 0, n_compared = 0;
   msp_sequencer #(.DAC_SLOT_CYCLES(40), .TRIG_MIN_CYCLES(4)) dut_u (.clk_i, .reset_n_i,
      .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
      .convert_trigger_n_i, .adc_start_o, .adc_pos_o, .adc_neg_o(), .adc_neg_gnd_o,
      .adc_ref_dac_o(), .adc_temp_o(), .adc_done_i, .adc_result_i, .dac_load_o, .dac_port_o,
      .temperature_channel_select_o(), .dac_data_o, .dac_ref_ext_o(), .ovc_i,
      .logic_input_port_i(12'h000), .logic_output_port_o(), .irq_out_n_o(), .irq_out_n_oe_o);
   msp_adc_model adc_u (.clk_i, .start_i(adc_start_o), .pos_i(adc_pos_o), .done_o(adc_done_i),
      .result_o(adc_result_i));
   initial forever #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) if (adc_start_o) q.push_back({adc_neg_gnd_o, adc_pos_o});
   task automatic chk(input logic [31:0] seen, exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task automatic wait_q(input int n);
      repeat (4000) if (q.size() < n) @(posedge clk_i);
   endtask : wait_q
   task automatic t_reset;
      apb(0, `MSP_OFF_CTRL, 0);
      chk(rd, 32'hC, "ctrl");
      apb(0, 8'hFC, 0);
      chk({31'h0, er}, 32'h1, "err");
   endtask : t_reset
   task automatic t_sweep;
      apb(1, 8'h08, 32'h4);
      apb(1, 8'h14, 32'h405);
      apb(1, `MSP_OFF_CTRL, 32'h11);
      wait_q(2);
      chk(q[0], 5'h12, "sweep0");
      chk(q[1], 5'h05, "sweep1");
      repeat (100) @(posedge clk_i);
      apb(0, 8'h88, 0);
      chk(rd, 32'h200, "se data");
      apb(0, 8'h94, 0);
      chk(rd, 32'hD00, "diff data");
   endtask : t_sweep
   task automatic t_single;
      logic [4:0] exp[3] = '{5'h12, 5'h05, 5'h12};
      q.delete();
      apb(1, `MSP_OFF_CTRL, 32'h2);
      apb(0, 8'h88, 0);
      chk(rd, 32'h0, "cleared");
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_i);
         convert_trigger_n_i <= 1'b0;
         repeat (6) @(posedge clk_i);
         convert_trigger_n_i <= 1'b1;
         wait_q(i + 1);
         repeat (50) @(posedge clk_i);
         chk(q[i], exp[i], "single");
      end
      repeat (2000) @(posedge clk_i);
      chk(q.size(), 3, "count");
   endtask : t_single
   task automatic t_dac;
      apb(1, 8'h1C, 32'h1);
      apb(1, 8'h5C, 32'hABC);
      repeat (2) @(posedge clk_i);
      repeat (1000) if (!(dac_load_o && dac_port_o == 4'h7)) @(posedge clk_i);
      chk(dac_data_o, 32'hABC, "dac");
   endtask : t_dac
   task automatic t_ovc;
      apb(1, `MSP_OFF_MASK, 32'h0);
      @(posedge clk_i);
      ovc_i <= 12'h080;
      @(posedge clk_i);
      ovc_i <= 12'h000;
      repeat (3) @(posedge clk_i);
      chk({31'h0, irq_out_n_oe_o}, 32'h1, "irq on");
      apb(0, `MSP_OFF_OVC, 0);
      chk(rd, 32'h80, "ovc status");
      apb(1, `MSP_OFF_OVC, 32'h80);
      repeat (3) @(posedge clk_i);
      chk({31'h0, irq_out_n_oe_o}, 32'h0, "irq off");
   endtask : t_ovc
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   initial begin
      repeat (30000) @(posedge clk_i);
      fails++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      reset_n_i <= 1'b1;
      t_reset();
      t_sweep();
      t_single();
      t_dac();
      t_ovc();
      end_sim();
   end
endmodule : mixed_signal_port_sequencer_tb
